/* File: design/psae_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the top module and the test bench
`ifndef PSAE_REGS_SVH
`define PSAE_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PSAE_OFS_CTRL   8'h00
`define PSAE_OFS_STATUS 8'h04
`define PSAE_OFS_MASK   8'h08
`define PSAE_OFS_ROUTE  8'h0C
`define PSAE_OFS_STATE  8'h10

// ****************************************
// control fields
// ****************************************
`define PSAE_CTRL_ARB_EN  0
`define PSAE_CTRL_GPI_SEL 1
`define PSAE_CTRL_GNT4_GP 4
`define PSAE_CTRL_GP_OUT  5
`define PSAE_CTRL_SBR     6
`define PSAE_CTRL_PME_DRV 7
`define PSAE_CTRL_RST     32'h0000_0001

// ****************************************
// status and mask fields
// ****************************************
`define PSAE_ST_INT_PERR 0
`define PSAE_ST_EXT_PERR 1
`define PSAE_ST_SERR     2
`define PSAE_ST_PME      3
`define PSAE_ST_W        4
`define PSAE_MASK_RST    32'h0000_0000

// ****************************************
// routing fields
// ****************************************
`define PSAE_RT_PERR_NMI 0
`define PSAE_RT_PERR_SMI 1
`define PSAE_RT_SERR_NMI 2
`define PSAE_RT_SERR_SMI 3
`define PSAE_RT_SERR_INT 4
`define PSAE_RT_PME_SCI  5
`define PSAE_ROUTE_RST   32'h0000_0000

// ****************************************
// state read-back fields
// ****************************************
`define PSAE_SV_STRAP 8
`define PSAE_SV_LOCK  9
`define PSAE_SV_GPI   10
`define PSAE_SV_PGOOD 13

// ****************************************
// timing
// ****************************************
`define PSAE_PERR_ECHO_CYC 3

`endif

/* File: design/psae_pkg.sv */
// types shared by the sideband arbiter design
// does not include the register header
package psae_pkg;
  // arbiter states
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_OWN  = 2'b01,
    ARB_TURN = 2'b10
  } psae_arb_state_t;
endpackage : psae_pkg

/* File: design/psae_sync.sv */
// multi-bit pin synchroniser of STAGES stages, two or more, with clock enable
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ps
module psae_sync #(
  parameter int          WIDTH   = 1,
  parameter int          STAGES  = 2,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r [STAGES];

  // refuse settings the chain cannot serve
  initial begin
    if (STAGES < 2 || WIDTH < 1 || WIDTH > 16) begin
      $error("psae_sync: bad STAGES or WIDTH");
    end
  end

  // first stage read only by the next stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int s = 0; s < STAGES; s++) begin
        meta_r[s] <= RST_VAL[WIDTH-1:0];
      end
    end else if (i_ce) begin
      meta_r[0] <= i_async;
      for (int s = 1; s < STAGES; s++) begin
        meta_r[s] <= meta_r[s-1];
      end
    end
  end

  assign o_sync = meta_r[STAGES-1];
endmodule : psae_sync

/* File: design/psae_top.sv */
// sideband control of a parallel bus: arbiter, error and wake reporting
// assumes one bus clock, apb master on the same clock, pins sampled here
//
// How it works
// - A parity error found in received data drives the parity error pin low.
// - Internal or reported parity errors can raise the nmi or sys-mgmt irq.
// - Seven to nine masters each get a request input and active-low grant.
// - Requests of masters four to six can serve as general inputs instead.
// - The grant of master four can serve as a general output instead.
// - The grant-six pin level is caught at power good rising as a strap.
// - Every bus action is timed by the single bus clock input.
// - The lock pin is ignored while an outside master holds the grant.
// - A sampled system error can raise nmi, sys-mgmt irq or plain irq.
// - In S0 with its enable set, the wake pin raises the sys-control irq.
// - The wake pin is only ever pulled low here, never driven high.
`timescale 1ns/1ps
`include "psae_regs.svh"
module psae_top #(
  parameter int NUM_MASTERS = 7
) (
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST,
  input  wire logic                   I_CE,
  input  wire logic                   I_PSEL,
  input  wire logic                   I_PENABLE,
  input  wire logic                   I_PWRITE,
  input  wire logic [7:0]             I_PADDR,
  input  wire logic [31:0]            I_PWDATA,
  output logic      [31:0]            O_PRDATA,
  output logic                        O_PREADY,
  output logic                        O_PSLVERR,
  input  wire logic [NUM_MASTERS-1:0] I_REQ_N,
  output logic      [NUM_MASTERS-1:0] O_GNT_N,
  output logic                        O_GNT6_OE,
  input  wire logic                   I_GNT6_PIN,
  input  wire logic                   I_DEV_REQ,
  output logic                        O_DEV_GNT,
  input  wire logic                   I_RX_VALID,
  input  wire logic [31:0]            I_RX_DATA,
  input  wire logic [3:0]             I_RX_CBE_N,
  input  wire logic                   I_RX_PAR,
  input  wire logic                   I_PERR_N,
  output logic                        O_PERR_N,
  output logic                        O_PERR_OE,
  input  wire logic                   I_SERR_N,
  input  wire logic                   I_BUS_LOCK_N,
  input  wire logic                   I_PME_N,
  output logic                        O_PME_N,
  output logic                        O_PME_OE,
  input  wire logic                   I_SYS_S0,
  input  wire logic                   I_PLATFORM_RESET_N,
  input  wire logic                   I_POWER_GOOD,
  output logic                        O_SECONDARY_BUS_RESET_N,
  output logic      [2:0]             O_GP_INPUT,
  output logic                        O_NMI,
  output logic                        O_SYS_MGMT_IRQ,
  output logic                        O_INTR,
  output logic                        O_SYS_CONTROL_IRQ,
  output logic                        O_IRQ
);
  import psae_pkg::*;

  localparam int NR = NUM_MASTERS + 1;
  localparam int IW = $clog2(NR);
  localparam int NS = NUM_MASTERS + 7;

  // refuse master counts the pin sharing cannot serve
  initial begin
    if (NUM_MASTERS < 7 || NUM_MASTERS > 9) begin
      $error("psae_top: NUM_MASTERS must be 7 to 9");
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NS-1:0]          pin_sync;
  logic [NUM_MASTERS-1:0] req_n_s;
  logic perr_n_s, serr_n_s, lock_n_s, pme_n_s, prst_n_s, pgood_s, gnt6_s;

  psae_sync #(
    .WIDTH   (NS),
    .STAGES  (2),
    .RST_VAL (16'hFFFF ^ (16'h0001 << (NUM_MASTERS + 5))) // pgood low
  ) u_sync (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_ce    (I_CE),
    .i_async ({I_GNT6_PIN, I_POWER_GOOD, I_PLATFORM_RESET_N, I_PME_N,
               I_BUS_LOCK_N, I_SERR_N, I_PERR_N, I_REQ_N}),
    .o_sync  (pin_sync)
  );

  assign req_n_s  = pin_sync[NUM_MASTERS-1:0];
  assign perr_n_s = pin_sync[NUM_MASTERS];
  assign serr_n_s = pin_sync[NUM_MASTERS+1];
  assign lock_n_s = pin_sync[NUM_MASTERS+2];
  assign pme_n_s  = pin_sync[NUM_MASTERS+3];
  assign prst_n_s = pin_sync[NUM_MASTERS+4];
  assign pgood_s  = pin_sync[NUM_MASTERS+5];
  assign gnt6_s   = pin_sync[NUM_MASTERS+6];

  // ****************************************
  // registers and apb slave
  // ****************************************
  logic [31:0]         ctrl_r, mask_r, route_r, rdata_nxt;
  logic [`PSAE_ST_W-1:0] status_r, status_set;
  logic [NR-1:0]       gnt_r;
  logic                strap_r, pgood_d_r, pgood_seen_r, lock_held_r;
  logic                wr_en, hit;

  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  assign hit   = (I_PADDR == `PSAE_OFS_CTRL)  | (I_PADDR == `PSAE_OFS_STATUS)
               | (I_PADDR == `PSAE_OFS_MASK)  | (I_PADDR == `PSAE_OFS_ROUTE)
               | (I_PADDR == `PSAE_OFS_STATE);

  // read mux, captured in the setup cycle
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (I_PADDR)
      `PSAE_OFS_CTRL:   rdata_nxt = ctrl_r;
      `PSAE_OFS_STATUS: rdata_nxt[`PSAE_ST_W-1:0] = status_r;
      `PSAE_OFS_MASK:   rdata_nxt = mask_r;
      `PSAE_OFS_ROUTE:  rdata_nxt = route_r;
      `PSAE_OFS_STATE: begin
        rdata_nxt[NR-1:0]        = gnt_r;
        rdata_nxt[`PSAE_SV_STRAP] = strap_r;
        rdata_nxt[`PSAE_SV_LOCK]  = lock_held_r;
        rdata_nxt[`PSAE_SV_GPI+:3] = O_GP_INPUT;
        rdata_nxt[`PSAE_SV_PGOOD] = pgood_seen_r;
      end
      default:          rdata_nxt = 32'h0000_0000;
    endcase
  end

  // zero-wait answer: ready in the first access cycle
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
    end else if (I_CE) begin
      if (I_PSEL & ~I_PENABLE) begin
        O_PREADY  <= 1'b1;
        O_PSLVERR <= ~hit;
        O_PRDATA  <= I_PWRITE ? 32'h0000_0000 : rdata_nxt;
      end else begin
        O_PREADY  <= 1'b0;
        O_PSLVERR <= 1'b0;
      end
    end
  end

  // writable registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl_r  <= `PSAE_CTRL_RST;
      mask_r  <= `PSAE_MASK_RST;
      route_r <= `PSAE_ROUTE_RST;
    end else if (I_CE && wr_en && !O_PSLVERR) begin
      if (I_PADDR == `PSAE_OFS_CTRL)  ctrl_r  <= I_PWDATA & 32'h0000_00FF;
      if (I_PADDR == `PSAE_OFS_MASK)  mask_r  <= I_PWDATA & 32'h0000_000F;
      if (I_PADDR == `PSAE_OFS_ROUTE) route_r <= I_PWDATA & 32'h0000_003F;
    end
  end

  // sticky status, a new event beats a write-one clear
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      status_r <= '0;
    end else if (I_CE) begin
      if (wr_en && I_PADDR == `PSAE_OFS_STATUS) begin
        status_r <= (status_r & ~I_PWDATA[`PSAE_ST_W-1:0]) | status_set;
      end else begin
        status_r <= status_r | status_set;
      end
    end
  end

  // ****************************************
  // arbiter
  // ****************************************
  psae_arb_state_t  state_r, state_nxt;
  logic [NR-1:0]    req_act, gnt_nxt;
  logic [IW-1:0]    owner_r, owner_nxt, pick;
  logic [2:0]       gpi_sel;
  logic             gnt4_gp;

  assign gpi_sel = ctrl_r[`PSAE_CTRL_GPI_SEL+:3];
  assign gnt4_gp = ctrl_r[`PSAE_CTRL_GNT4_GP];

  // active requests, shared pins removed from arbitration
  always_comb begin
    req_act = {I_DEV_REQ, ~req_n_s};
    for (int k = 0; k < 3; k++) begin
      if (gpi_sel[k]) req_act[4+k] = 1'b0;
    end
    if (gnt4_gp) req_act[4] = 1'b0;
  end

  // round robin: nearest requester after the last owner
  always_comb begin
    int j;
    j    = 0;
    pick = owner_r;
    for (int k = NR; k >= 1; k--) begin
      j = (int'(owner_r) + k) % NR;
      if (req_act[j]) pick = IW'(j);
    end
  end

  // grant sequencing with an idle turnaround between owners
  always_comb begin
    state_nxt = state_r;
    owner_nxt = owner_r;
    gnt_nxt   = gnt_r;
    unique case (state_r)
      ARB_IDLE: begin
        gnt_nxt = '0;
        if (ctrl_r[`PSAE_CTRL_ARB_EN] && (|req_act)) begin
          owner_nxt      = pick;
          gnt_nxt[pick]  = 1'b1;
          state_nxt      = ARB_OWN;
        end
      end
      ARB_OWN: begin
        if (!req_act[owner_r] || !ctrl_r[`PSAE_CTRL_ARB_EN]) begin
          gnt_nxt   = '0;
          state_nxt = ARB_TURN;
        end
      end
      ARB_TURN: begin
        gnt_nxt   = '0;
        state_nxt = ARB_IDLE;
      end
      default: begin
        gnt_nxt   = '0;
        state_nxt = ARB_IDLE;
      end
    endcase
  end

  // grants move only at a clock edge
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_r <= ARB_IDLE;
      owner_r <= IW'(NUM_MASTERS);
      gnt_r   <= '0;
    end else if (I_CE) begin
      state_r <= state_nxt;
      owner_r <= owner_nxt;
      gnt_r   <= gnt_nxt;
    end
  end

  // grant pins, master four may carry the general output
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_GNT_N   <= '1;
      O_DEV_GNT <= 1'b0;
    end else if (I_CE) begin
      O_GNT_N   <= ~gnt_nxt[NUM_MASTERS-1:0];
      if (gnt4_gp) O_GNT_N[4] <= ctrl_r[`PSAE_CTRL_GP_OUT];
      O_DEV_GNT <= gnt_nxt[NUM_MASTERS];
    end
  end

  // general inputs read from shared request pins
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_GP_INPUT <= 3'b000;
    end else if (I_CE) begin
      O_GP_INPUT <= gpi_sel & ~req_n_s[6:4];
    end
  end

  // lock tracked only while this device owns the bus
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      lock_held_r <= 1'b0;
    end else if (I_CE) begin
      if (gnt_r[NUM_MASTERS]) lock_held_r <= ~lock_n_s;
      else                    lock_held_r <= 1'b0;
    end
  end

  // ****************************************
  // strap, power and secondary reset
  // ****************************************
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pgood_d_r    <= 1'b0;
      pgood_seen_r <= 1'b0;
      strap_r      <= 1'b0;
      O_GNT6_OE    <= 1'b0;
    end else if (I_CE) begin
      pgood_d_r <= pgood_s;
      if (pgood_s && !pgood_d_r) begin
        strap_r      <= gnt6_s;
        pgood_seen_r <= 1'b1;
      end else if (!pgood_s) begin
        pgood_seen_r <= 1'b0;
      end
      O_GNT6_OE <= pgood_seen_r;
    end
  end

  // secondary reset follows platform reset or the control bit
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_SECONDARY_BUS_RESET_N <= 1'b0;
    end else if (I_CE) begin
      O_SECONDARY_BUS_RESET_N <= prst_n_s & ~ctrl_r[`PSAE_CTRL_SBR];
    end
  end

  // ****************************************
  // parity, system error and wake events
  // ****************************************
  logic       par_pend_r, par_acc_r, serr_d_r, perr_d_r, pme_d_r;
  logic [`PSAE_PERR_ECHO_CYC-1:0] own_perr_r;
  logic       int_perr;

  assign int_perr = par_pend_r & (par_acc_r ^ I_RX_PAR);

  // even parity over data and byte enables, checked a cycle later
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      par_pend_r <= 1'b0;
      par_acc_r  <= 1'b0;
      O_PERR_N   <= 1'b1;
      O_PERR_OE  <= 1'b0;
      own_perr_r <= '0;
    end else if (I_CE) begin
      par_pend_r <= I_RX_VALID;
      par_acc_r  <= ^{I_RX_DATA, I_RX_CBE_N};
      O_PERR_N   <= ~int_perr;
      O_PERR_OE  <= int_perr;
      own_perr_r <= {own_perr_r[`PSAE_PERR_ECHO_CYC-2:0], int_perr};
    end
  end

  // edge history of sampled pins
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      serr_d_r <= 1'b1;
      perr_d_r <= 1'b1;
      pme_d_r  <= 1'b1;
    end else if (I_CE) begin
      serr_d_r <= serr_n_s;
      perr_d_r <= perr_n_s;
      pme_d_r  <= pme_n_s;
    end
  end

  // event strobes into the sticky status
  always_comb begin
    status_set = '0;
    status_set[`PSAE_ST_INT_PERR] = int_perr;
    status_set[`PSAE_ST_EXT_PERR] = perr_d_r & ~perr_n_s
                                  & ~(|own_perr_r);
    status_set[`PSAE_ST_SERR]     = serr_d_r & ~serr_n_s;
    status_set[`PSAE_ST_PME]      = pme_d_r & ~pme_n_s & I_SYS_S0;
  end

  // wake pin is open drain: low or released
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PME_N  <= 1'b0;
      O_PME_OE <= 1'b0;
    end else if (I_CE) begin
      O_PME_N  <= 1'b0;
      O_PME_OE <= ctrl_r[`PSAE_CTRL_PME_DRV];
    end
  end

  // ****************************************
  // interrupt outputs
  // ****************************************
  logic perr_any, serr_any;
  assign perr_any = status_r[`PSAE_ST_INT_PERR] | status_r[`PSAE_ST_EXT_PERR];
  assign serr_any = status_r[`PSAE_ST_SERR];

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_NMI             <= 1'b0;
      O_SYS_MGMT_IRQ    <= 1'b0;
      O_INTR            <= 1'b0;
      O_SYS_CONTROL_IRQ <= 1'b0;
      O_IRQ             <= 1'b0;
    end else if (I_CE) begin
      O_NMI <= (perr_any & route_r[`PSAE_RT_PERR_NMI])
             | (serr_any & route_r[`PSAE_RT_SERR_NMI]);
      O_SYS_MGMT_IRQ <= (perr_any & route_r[`PSAE_RT_PERR_SMI])
                      | (serr_any & route_r[`PSAE_RT_SERR_SMI]);
      O_INTR <= serr_any & route_r[`PSAE_RT_SERR_INT];
      O_SYS_CONTROL_IRQ <= status_r[`PSAE_ST_PME]
                         & route_r[`PSAE_RT_PME_SCI];
      O_IRQ <= |(status_r & mask_r[`PSAE_ST_W-1:0]);
    end
  end
endmodule : psae_top

/* File: testbench/psae_top_asserts.sv */
// checker on the sideband arbiter top ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module psae_top_asserts #(
  parameter int NUM_MASTERS = 7
) (
  input wire logic                   I_CLK,
  input wire logic                   I_RST,
  input wire logic                   I_PSEL,
  input wire logic                   I_PENABLE,
  input wire logic [NUM_MASTERS-1:0] I_REQ_N,
  input wire logic                   I_RX_VALID,
  input wire logic                   I_PLATFORM_RESET_N,
  input wire logic                   O_PREADY,
  input wire logic                   O_PSLVERR,
  input wire logic [NUM_MASTERS-1:0] O_GNT_N,
  input wire logic                   O_DEV_GNT,
  input wire logic                   O_PERR_N,
  input wire logic                   O_PERR_OE,
  input wire logic                   O_PME_N,
  input wire logic                   O_PME_OE,
  input wire logic                   O_SECONDARY_BUS_RESET_N
);
  // ********************
  // port relations
  // ********************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // register bus answer timing
  chk_ready_setup: assert property (
    I_PSEL && !I_PENABLE |=> O_PREADY) else $error("ready missing");
  chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held");
  chk_slverr_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  // grants other than master four: at most one, each master pin only after its request
  chk_one_grant: assert property ($onehot0({~O_GNT_N[NUM_MASTERS-1:5],
    ~O_GNT_N[3:0], O_DEV_GNT})) else $error("two grants");
  for (genvar i = 0; i < NUM_MASTERS; i++) begin : g_cause
    if (i != 4) begin : g_pin
      chk_grant_cause: assert property (
        $fell(O_GNT_N[i]) |-> !$past(I_REQ_N[i], 2)) else $error("stray grant");
    end
  end
  // parity error pin drive
  chk_perr_pulse: assert property (
    O_PERR_OE |-> !O_PERR_N ##1 !O_PERR_OE) else $error("parity pulse bad");
  chk_perr_cause: assert property (
    $rose(O_PERR_OE) |-> $past(I_RX_VALID, 2) || $past(I_RX_VALID, 3))
    else $error("parity error uncaused");
  // wake pin and secondary reset
  chk_wake_low: assert property (O_PME_OE |-> !O_PME_N)
    else $error("wake driven high");
  chk_sec_reset: assert property (
    !I_PLATFORM_RESET_N [*5] |-> !O_SECONDARY_BUS_RESET_N)
    else $error("secondary reset missing");
  cov_refused: cover property (O_PSLVERR);
  cov_parity: cover property ($rose(O_PERR_OE));
  cov_device: cover property (O_DEV_GNT);
endmodule : psae_top_asserts

bind psae_top psae_top_asserts #(.NUM_MASTERS(NUM_MASTERS))
  u_psae_top_asserts (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_REQ_N(I_REQ_N), .I_RX_VALID(I_RX_VALID),
  .I_PLATFORM_RESET_N(I_PLATFORM_RESET_N), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_GNT_N(O_GNT_N), .O_DEV_GNT(O_DEV_GNT),
  .O_PERR_N(O_PERR_N), .O_PERR_OE(O_PERR_OE), .O_PME_N(O_PME_N),
  .O_PME_OE(O_PME_OE), .O_SECONDARY_BUS_RESET_N(O_SECONDARY_BUS_RESET_N));

/* File: testbench/psae_bus_agent.sv */
// model of the masters and agents on the parallel bus
// assumes wishes and events change just after a rising edge
`timescale 1ns/1ps
module psae_bus_agent (
  input  wire logic       i_clk,
  input  wire logic [6:0] i_want,
  input  wire logic [6:0] i_gnt_n,
  input  wire logic [2:0] i_ev,
  output logic      [6:0] o_req_n,
  output logic      [6:0] o_owned,
  output logic            o_perr_n,
  output logic            o_serr_n,
  output logic            o_pme_n
);
  // ********************
  // pin behaviour
  // ********************
  // idle pins, pulled high at start
  initial begin
    o_req_n = 7'h7F;
    o_owned = 7'h00;
    o_perr_n = 1'h1;
    o_serr_n = 1'h1;
    o_pme_n = 1'h1;
  end
  // requests move on rising edges, transfer only once granted
  always @(posedge i_clk) begin
    o_req_n <= ~i_want;
    o_owned <= i_want & ~o_req_n & ~i_gnt_n;
  end
  // error and wake pulls, released to the pull-up level
  always @(posedge i_clk) begin
    o_perr_n <= ~i_ev[0];
    o_serr_n <= ~i_ev[1];
    o_pme_n <= ~i_ev[2];
  end
endmodule : psae_bus_agent

/* File: testbench/test_psae_top.sv */
// self-checking bench for the sideband arbiter top
// assumes the bus agent and the bound checker are compiled first
`timescale 1ns/1ps
`include "psae_regs.svh"
module test_psae_top;
  import psae_pkg::*;
  // ********************
  // signals
  // ********************
  localparam logic [31:0] NONE = 32'h0000_0000;
  localparam logic [31:0] ONE  = 32'h0000_0001;
  localparam logic [31:0] ALL  = 32'hFFFF_FFFF;
  logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic        dreq = 1'h0, rx_v = 1'h0, rx_p = 1'h0, lock_n = 1'h1;
  logic        s0 = 1'h0, plat_n = 1'h1, pgood = 1'h0, err;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = NONE, rx_d = NONE, rdv;
  logic [6:0]  want = 7'h00;
  logic [2:0]  ev = 3'h0;
  logic [7:0]  rte [4] = '{8'h01, 8'h02, 8'h1C, 8'h20};
  logic [4:0]  exq [4] = '{5'h11, 5'h09, 5'h1C, 5'h03};
  wire  [31:0] prd;
  wire  [6:0]  req_n, gnt_n;
  wire  [2:0]  gp_input;
  wire  [4:0]  irqs;
  wire         prdy, slv, perr_n, perr_oe, pme_n, pme_oe, g6_oe, sbr_n, dgnt;
  wire         a_perr_n, a_serr_n, a_pme_n;
  int          bad_count = 0, checked = 0;
  // open-drain wires resolved from every driver
  wire         perr_w = a_perr_n & ~(perr_oe & ~perr_n);
  wire         pme_w = a_pme_n & ~(pme_oe & ~pme_n);
  wire         g6_w = g6_oe ? gnt_n[6] : 1'h1; // pull-up when released
  wire  [8:0]  gv = {prdy, dgnt, ~gnt_n};
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  psae_top u_psae_top (
    .I_CLK(clk), .I_RST(rst), .I_CE(1'h1), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prd),
    .O_PREADY(prdy), .O_PSLVERR(slv), .I_REQ_N(req_n), .O_GNT_N(gnt_n),
    .O_GNT6_OE(g6_oe), .I_GNT6_PIN(g6_w), .I_DEV_REQ(dreq), .O_DEV_GNT(dgnt),
    .I_RX_VALID(rx_v), .I_RX_DATA(rx_d), .I_RX_CBE_N(4'h1), .I_RX_PAR(rx_p),
    .I_PERR_N(perr_w), .O_PERR_N(perr_n), .O_PERR_OE(perr_oe),
    .I_SERR_N(a_serr_n), .I_BUS_LOCK_N(lock_n), .I_PME_N(pme_w),
    .O_PME_N(pme_n), .O_PME_OE(pme_oe), .I_SYS_S0(s0),
    .I_PLATFORM_RESET_N(plat_n), .I_POWER_GOOD(pgood),
    .O_SECONDARY_BUS_RESET_N(sbr_n), .O_GP_INPUT(gp_input), .O_NMI(irqs[4]),
    .O_SYS_MGMT_IRQ(irqs[3]), .O_INTR(irqs[2]), .O_SYS_CONTROL_IRQ(irqs[1]),
    .O_IRQ(irqs[0]));
  psae_bus_agent u_psae_bus_agent (
    .i_clk(clk), .i_want(want), .i_gnt_n(gnt_n), .i_ev(ev), .o_req_n(req_n),
    .o_owned(), .o_perr_n(a_perr_n), .o_serr_n(a_serr_n), .o_pme_n(a_pme_n));
  // ********************
  // tasks
  // ********************
  // compare and count
  task automatic chk(input logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic summarize;
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // bounded wait for ready or a grant bit
  task automatic wait_bit(input int i);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (gv[i] !== 1'h1 && n < 16);
    if (gv[i] !== 1'h1) begin
      bad_count++;
      $display("[FAIL] %0t wait %0d timed out", $time, i);
      summarize();
    end
  endtask : wait_bit
  // one register bus transfer, held until ready
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'h1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    wait_bit(8);
    rdv = prd;
    err = slv;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, logic [31:0] m, logic [31:0] e);
    apb(1'h0, a, NONE);
    chk(rdv & m, e);
  endtask : rd
  // received data phase, parity one cycle later
  task automatic rx(input logic [31:0] d, logic p);
    rx_v <= 1'h1;
    rx_d <= d;
    @(posedge clk);
    rx_v <= 1'h0;
    rx_p <= p;
    @(posedge clk);
  endtask : rx
  // event k: bad parity, outside parity error, system error, wake
  task automatic fire(input int k);
    if (k == 0) begin
      rx(32'h0000_0003, 1'h0);
    end else begin
      ev[k-1] <= 1'h1;
      tick(2);
      ev[k-1] <= 1'h0;
    end
  endtask : fire
  // ********************
  // main sequence
  // ********************
  initial begin
    tick(4);
    rst <= 1'h0;
    rd(`PSAE_OFS_CTRL, ALL, `PSAE_CTRL_RST);
    rd(`PSAE_OFS_STATUS, ALL, NONE);
    rd(`PSAE_OFS_MASK, ALL, `PSAE_MASK_RST);
    rd(`PSAE_OFS_ROUTE, ALL, `PSAE_ROUTE_RST);
    rd(8'h14, ALL, NONE);
    chk(err, ONE);
    rd(`PSAE_OFS_STATE, 32'h0000_2100, NONE);
    pgood <= 1'h1;
    tick(6);
    rd(`PSAE_OFS_STATE, 32'h0000_2100, 32'h0000_2100);
    chk(g6_oe, ONE);
    chk(sbr_n, ONE);
    wr(`PSAE_OFS_CTRL, 32'h0000_0041);
    tick(2);
    chk(sbr_n, NONE);
    wr(`PSAE_OFS_CTRL, ONE);
    plat_n <= 1'h0;
    tick(6);
    chk(sbr_n, NONE);
    plat_n <= 1'h1;
    want <= 7'h04;
    wait_bit(2);
    dreq <= 1'h1;
    lock_n <= 1'h0;
    tick(6);
    rd(`PSAE_OFS_STATE, 32'h0000_02FF, 32'h0000_0004);
    want <= 7'h00;
    lock_n <= 1'h1;
    wait_bit(7);
    lock_n <= 1'h0;
    tick(4);
    rd(`PSAE_OFS_STATE, 32'h0000_0280, 32'h0000_0280);
    lock_n <= 1'h1;
    chk(sbr_n, ONE);
    dreq <= 1'h0;
    wr(`PSAE_OFS_CTRL, 32'h0000_000F);
    want <= 7'h70;
    tick(6);
    chk({gp_input, gv[7:0]}, 32'h0000_0700);
    wr(`PSAE_OFS_CTRL, 32'h0000_0003);
    tick(6);
    chk({gp_input, |gv[6:5]}, 32'h0000_0003);
    want <= 7'h00;
    wr(`PSAE_OFS_CTRL, 32'h0000_0011);
    tick(2);
    chk(gnt_n[4], NONE);
    wr(`PSAE_OFS_CTRL, 32'h0000_0031);
    tick(2);
    chk(gnt_n[4], ONE);
    wr(`PSAE_OFS_CTRL, 32'h0000_0081);
    tick(2);
    chk({pme_oe, pme_n}, 32'h0000_0002);
    wr(`PSAE_OFS_CTRL, ONE);
    rd(`PSAE_OFS_STATUS, ALL, NONE);
    s0 <= 1'h1;
    rx(32'h0000_0003, 1'h1);
    tick(6);
    rd(`PSAE_OFS_STATUS, ALL, NONE);
    for (int k = 0; k < 4; k++) begin
      wr(`PSAE_OFS_ROUTE, 32'(rte[k]));
      wr(`PSAE_OFS_MASK, (k == 2) ? NONE : ONE << k);
      fire(k);
      tick(8);
      rd(`PSAE_OFS_STATUS, ALL, ONE << k);
      chk(irqs, exq[k]);
      wr(`PSAE_OFS_STATUS, ONE << k);
      tick(2);
      rd(`PSAE_OFS_STATUS, ALL, NONE);
      chk(irqs, NONE);
    end
    summarize();
  end
endmodule : test_psae_top
